// >>> design/brf_pkg.sv
// constants and types of the breaker failure backup trip block
// How it works
// - backup timer starts on rising edge of general start input.
// - one combined general start only; no per-phase start inputs.
// - mode is off, current, contact or both; off after reset.
// - current mode ignores the breaker closed-status input.
// - contact mode ignores currents; clearance judged from breaker status alone.
// - phase limit 20..200 pct default 30, residual 10..200 default 20.
// - combined mode idles only when currents low and breaker open.
// - at timer expiry, trip if supervised fault still present.
// - backup delay 60..1000 ms, step 1, default 200.
// - trip held for the pulse length, at least one tick, 0..60000 ms, default 100.
// - operation off means no trip, no new interrupts and no supervision.
// - block input inhibits operation while asserted.
package brf_pkg;
    // ***********************
    // timing
    // ***********************
    localparam int CLK_MHZ       = 200;
    localparam int TICK_US       = 1000;
    localparam int TICK_CYCLES   = TICK_US * CLK_MHZ;
    localparam int TICK_W        = 18;
    localparam int MS_W          = 16;
    // ***********************
    // settings ranges and defaults
    // ***********************
    localparam logic [MS_W-1:0] DELAY_MIN   = 16'h003c;
    localparam logic [MS_W-1:0] DELAY_MAX   = 16'h03e8;
    localparam logic [MS_W-1:0] DELAY_DEF   = 16'h00c8;
    localparam logic [MS_W-1:0] PULSE_MAX   = 16'hea60;
    localparam logic [MS_W-1:0] PULSE_DEF   = 16'h0064;
    localparam logic [7:0]      PH_MIN      = 8'h14;
    localparam logic [7:0]      PH_MAX      = 8'hc8;
    localparam logic [7:0]      PH_DEF      = 8'h1e;
    localparam logic [7:0]      RES_MIN     = 8'h0a;
    localparam logic [7:0]      RES_MAX     = 8'hc8;
    localparam logic [7:0]      RES_DEF     = 8'h14;
    localparam int              CUR_W       = 8;
    // ***********************
    // register map
    // ***********************
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_LIMITS = 8'h04;
    localparam logic [7:0] OFF_DELAY  = 8'h08;
    localparam logic [7:0] OFF_PULSE  = 8'h0c;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_IRQST  = 8'h14;
    localparam logic [7:0] OFF_IRQMSK = 8'h18;
    localparam int IRQ_START = 0;
    localparam int IRQ_TRIP  = 1;
    localparam int IRQ_CLEAR = 2;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // ***********************
    // types
    // ***********************
    typedef enum logic [1:0] {
        MODE_OFF     = 2'h0,
        MODE_CURRENT = 2'h1,
        MODE_CONTACT = 2'h2,
        MODE_BOTH    = 2'h3
    } mode_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_TIME = 3'b010,
        ST_TRIP = 3'b100
    } state_t;
endpackage

// >>> design/ms_tick.sv
// prescaler producing a one-cycle millisecond tick
`timescale 1ns/10ps
module ms_tick (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // tick out
    output logic      tick
);
    import brf_pkg::*;
    logic [TICK_W-1:0] cnt_r;
    // ***********************
    // counter
    // ***********************
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= '0;
            tick  <= 1'b0;
        end else if (cnt_r == TICK_W'(TICK_CYCLES - 1)) begin
            cnt_r <= '0;
            tick  <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 1'b1;
            tick  <= 1'b0;
        end
    end
endmodule

// >>> design/breaker_failure_function.sv
// breaker failure supervision with axi4-lite settings and interrupts
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
module breaker_failure_function (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst,
    // protection inputs
    input  wire logic                      generalStartInput,
    input  wire logic                      blockInput,
    input  wire logic                      breakerClosed,
    input  wire logic [brf_pkg::CUR_W-1:0] phaseCurrentA,
    input  wire logic [brf_pkg::CUR_W-1:0] phaseCurrentB,
    input  wire logic [brf_pkg::CUR_W-1:0] phaseCurrentC,
    input  wire logic [brf_pkg::CUR_W-1:0] residualCurrent,
    // trip and interrupt outputs
    output logic                           backupTrip,
    output logic                           irq,
    // axi4-lite write
    input  wire logic [7:0]                s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]                s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready
);
    import brf_pkg::*;

    // ***********************
    // input synchronisers
    // ***********************
    logic [2:0] meta_r;
    logic [2:0] sync_r;
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= {breakerClosed, blockInput, generalStartInput};
            sync_r <= meta_r;
        end
    end
    logic startS;
    logic blockS;
    logic closedS;
    assign startS  = sync_r[0];
    assign blockS  = sync_r[1];
    assign closedS = sync_r[2];

    // ***********************
    // settings registers
    // ***********************
    mode_t           mode_r;
    logic [7:0]      phLimit_r;
    logic [7:0]      resLimit_r;
    logic [MS_W-1:0] delay_r;
    logic [MS_W-1:0] pulse_r;
    logic [2:0]      irqSt_r;
    logic [2:0]      irqMsk_r;

    // clamp to the legal range so a bad write can't break timing
    function automatic logic [MS_W-1:0] clampMs(input logic [MS_W-1:0] v,
                                                input logic [MS_W-1:0] lo,
                                                input logic [MS_W-1:0] hi);
        if (v < lo)
            return lo;
        else if (v > hi)
            return hi;
        else
            return v;
    endfunction

    // ***********************
    // axi4-lite write path
    // ***********************
    logic       awHeld_r;
    logic       wHeld_r;
    logic [7:0] awAddr_r;
    logic [31:0] wData_r;
    logic [3:0] wStrb_r;
    logic       doWrite;
    assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld_r && !s_axi_bvalid;
    assign doWrite       = awHeld_r && wHeld_r && !s_axi_bvalid;

    always_ff @(posedge clk) begin
        if (rst) begin
            awHeld_r <= 1'b0;
            wHeld_r  <= 1'b0;
            awAddr_r <= '0;
            wData_r  <= '0;
            wStrb_r  <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_r <= 1'b1;
                awAddr_r <= s_axi_awaddr;
            end else if (doWrite) begin
                awHeld_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_r <= 1'b1;
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
            end else if (doWrite) begin
                wHeld_r <= 1'b0;
            end
        end
    end

    logic wrHit;
    always_comb begin
        case ({awAddr_r[7:2], 2'b00})
            OFF_CTRL, OFF_LIMITS, OFF_DELAY, OFF_PULSE,
            OFF_IRQST, OFF_IRQMSK: wrHit = 1'b1;
            default:               wrHit = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wrHit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    logic [15:0] wrLo;
    assign wrLo = {wStrb_r[1] ? wData_r[15:8] : 8'h00,
                   wStrb_r[0] ? wData_r[7:0]  : 8'h00};

    always_ff @(posedge clk) begin
        if (rst) begin
            mode_r     <= MODE_OFF;
            phLimit_r  <= PH_DEF;
            resLimit_r <= RES_DEF;
            delay_r    <= DELAY_DEF;
            pulse_r    <= PULSE_DEF;
            irqMsk_r   <= '0;
        end else if (doWrite && wStrb_r[0]) begin
            case ({awAddr_r[7:2], 2'b00})
                OFF_CTRL: begin
                    mode_r <= mode_t'(wData_r[1:0]);
                end
                OFF_LIMITS: begin
                    phLimit_r  <= 8'(clampMs({8'h00, wData_r[7:0]},
                                  {8'h00, PH_MIN}, {8'h00, PH_MAX}));
                    resLimit_r <= 8'(clampMs({8'h00, wData_r[15:8]},
                                  {8'h00, RES_MIN}, {8'h00, RES_MAX}));
                end
                OFF_DELAY: begin
                    delay_r <= clampMs(wrLo, DELAY_MIN, DELAY_MAX);
                end
                OFF_PULSE: begin
                    pulse_r <= clampMs(wrLo, 16'h0000, PULSE_MAX);
                end
                OFF_IRQMSK: begin
                    irqMsk_r <= wData_r[2:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ***********************
    // supervision
    // ***********************
    logic active;
    logic curHigh;
    logic faultPresent;
    // currents come from logic on this clock, so they skip the synchronisers
    assign active  = (mode_r != MODE_OFF) && !blockS;
    assign curHigh = (phaseCurrentA >= phLimit_r) ||
                     (phaseCurrentB >= phLimit_r) ||
                     (phaseCurrentC >= phLimit_r) ||
                     (residualCurrent >= resLimit_r);
    always_comb begin
        case (mode_r)
            MODE_CURRENT: faultPresent = curHigh;
            MODE_CONTACT: faultPresent = closedS;
            MODE_BOTH:    faultPresent = curHigh || closedS;
            default:      faultPresent = 1'b0;
        endcase
    end

    // ***********************
    // state machine and timers
    // ***********************
    logic            tick;
    logic            startDly_r;
    logic            startEdge;
    state_t          state_r;
    logic [MS_W-1:0] msCnt_r;
    logic            evStart;
    logic            evTrip;
    logic            evClear;

    // tick phase runs free, so a timed delay may end up to one tick short
    ms_tick u_tick (
        .clk  (clk),
        .rst  (rst),
        .tick (tick)
    );

    always_ff @(posedge clk) begin
        if (rst)
            startDly_r <= 1'b0;
        else
            startDly_r <= startS;
    end
    assign startEdge = startS && !startDly_r;

    assign evStart = (state_r == ST_IDLE) && active && startEdge;
    assign evClear = (state_r == ST_TIME) && active && !faultPresent;
    assign evTrip  = (state_r == ST_TIME) && active && faultPresent &&
                     tick && (msCnt_r + 1'b1 >= delay_r);

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= ST_IDLE;
            msCnt_r <= '0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    msCnt_r <= '0;
                    if (evStart)
                        state_r <= ST_TIME;
                end
                ST_TIME: begin
                    if (!active || evClear) begin
                        state_r <= ST_IDLE;
                        msCnt_r <= '0;
                    end else if (evTrip) begin
                        state_r <= ST_TRIP;
                        msCnt_r <= '0;
                    end else if (tick) begin
                        msCnt_r <= msCnt_r + 1'b1;
                    end
                end
                ST_TRIP: begin
                    // pulse length 0 still yields a single-tick trip
                    if (!active) begin
                        state_r <= ST_IDLE;
                        msCnt_r <= '0;
                    end else if (tick && (msCnt_r + 1'b1 >= pulse_r)) begin
                        state_r <= ST_IDLE;
                        msCnt_r <= '0;
                    end else if (tick) begin
                        msCnt_r <= msCnt_r + 1'b1;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                    msCnt_r <= '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst)
            backupTrip <= 1'b0;
        else
            backupTrip <= (state_r == ST_TRIP) && active;
    end

    // ***********************
    // interrupts
    // ***********************
    logic [2:0] irqSet;
    logic [2:0] irqClr;
    assign irqSet = {evClear, evTrip, evStart};
    assign irqClr = (doWrite && wStrb_r[0] &&
                     {awAddr_r[7:2], 2'b00} == OFF_IRQST) ?
                    wData_r[2:0] : 3'b000;
    always_ff @(posedge clk) begin
        if (rst)
            irqSt_r <= '0;
        else
            irqSt_r <= (irqSt_r & ~irqClr) | irqSet; // set wins over clear
    end
    always_ff @(posedge clk) begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= |(irqSt_r & irqMsk_r);
    end

    // ***********************
    // axi4-lite read path
    // ***********************
    logic [31:0] rdVal;
    logic        rdHit;
    always_comb begin
        rdHit = 1'b1;
        case ({s_axi_araddr[7:2], 2'b00})
            OFF_CTRL:   rdVal = {30'h0, mode_r};
            OFF_LIMITS: rdVal = {16'h0, resLimit_r, phLimit_r};
            OFF_DELAY:  rdVal = {16'h0, delay_r};
            OFF_PULSE:  rdVal = {16'h0, pulse_r};
            OFF_STATUS: rdVal = {8'h0, msCnt_r, 1'b0, curHigh, closedS,
                                 blockS, backupTrip, state_r};
            OFF_IRQST:  rdVal = {29'h0, irqSt_r};
            OFF_IRQMSK: rdVal = {29'h0, irqMsk_r};
            default: begin
                rdVal = 32'h0000_0000;
                rdHit = 1'b0;
            end
        endcase
    end
    // one read at a time: arready drops while the answer waits
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdVal;
            s_axi_rresp  <= rdHit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// >>> tb/brf_chk.sv
// assertions on the ports of the breaker failure block
`timescale 1ns/10ps
module brf_chk (
    // clock and reset
    input wire logic       clk,
    input wire logic       rst,
    // protection pins
    input wire logic       generalStartInput,
    input wire logic       blockInput,
    input wire logic       backupTrip,
    input wire logic       irq,
    // bus handshakes
    input wire logic       s_axi_awready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic       s_axi_rready
);
    import brf_pkg::*;
    localparam int MIN_TRIP = int'(DELAY_MIN) * TICK_CYCLES;
    logic [31:0] upCnt_r;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // cycles since reset; no trip can come sooner than the shortest delay
    always_ff @(posedge clk) begin
        if (rst)
            upCnt_r <= '0;
        else if (upCnt_r < MIN_TRIP)
            upCnt_r <= upCnt_r + 32'h1;
    end
    AST_RST_CLEAR: assert property (disable iff (1'b0) rst |=>
        !backupTrip && !irq && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs not cleared by reset");
    AST_EARLY_TRIP: assert property ($rose(backupTrip) |->
        upCnt_r >= MIN_TRIP) else $error("trip before minimum delay");
    AST_BLOCK: assert property (blockInput [*5] |-> !backupTrip)
        else $error("trip while blocked");
    AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid) else $error("bvalid dropped early");
    AST_RVALID_HOLD: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid) else $error("rvalid dropped early");
    AST_AW_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("awready during write response");
    AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("arready during read response");
    AST_ONE_READ: assert property (s_axi_rvalid && s_axi_rready
        |=> !s_axi_rvalid) else $error("second read without request");
    AST_RESP_CODE: assert property (s_axi_bvalid |->
        s_axi_bresp == RESP_OKAY || s_axi_bresp == RESP_SLVERR)
        else $error("illegal write response");
    COV_IRQ: cover property ($rose(irq));
    COV_SLVERR: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
    COV_BLOCK: cover property (blockInput [*5]);
endmodule
bind breaker_failure_function brf_chk chk_u (.clk, .rst,
    .generalStartInput, .blockInput, .backupTrip, .irq, .s_axi_awready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready);

// >>> tb/breaker_model.sv
// backup breaker partner: closed contact with opening delay and bounce
`timescale 1ns/10ps
module breaker_model #(
    parameter int OPEN_DLY = 6
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // commands
    input  wire logic closeCmd,
    input  wire logic backupTrip,
    // contact
    output logic      breakerClosed
);
    logic [7:0] openCnt_r;
    // the contact bounces on its way open, so no clean edge is promised
    always_ff @(posedge clk) begin
        if (rst || (closeCmd && !backupTrip)) begin
            openCnt_r     <= rst ? 8'(OPEN_DLY) : 8'h00;
            breakerClosed <= closeCmd && !rst;
        end else if (openCnt_r < OPEN_DLY) begin
            openCnt_r     <= openCnt_r + 8'h01;
            breakerClosed <= (openCnt_r > 8'(OPEN_DLY / 2)) ?
                             !breakerClosed : 1'b1;
        end else
            breakerClosed <= 1'b0;
    end
endmodule

// >>> tb/tb.sv
// self-checking bench of the breaker failure block
`timescale 1ns/10ps
module tb;
    import brf_pkg::*;
    logic clk, rst, generalStartInput, blockInput, breakerClosed, closeCmd;
    logic [7:0] phaseCurrentA, phaseCurrentB, phaseCurrentC, residualCurrent;
    logic backupTrip, irq, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    integer seed;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    breaker_failure_function dut_u (.*);
    breaker_model #(.OPEN_DLY(6)) brk_u (.clk(clk), .rst(rst),
        .closeCmd(closeCmd), .backupTrip(backupTrip),
        .breakerClosed(breakerClosed));
    always #2.5 clk = ~clk;
    // the millisecond counts are too long to run out, so cap the run here
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            n_errors++;
            stop_test();
        end
    end
    task automatic stop_test;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // ***********************
    // bus master; handshakes are judged mid-cycle, acted on at the edge
    // ***********************
    task automatic axi(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic [1:0] r);
        logic a1, d1, rs;
        rs = 0;
        q = '0;
        r = '0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        // no wait limit of its own: a hang runs into the cycle cap
        while (!rs) begin
            @(negedge clk);
            a1 = w ? s_axi_awvalid && s_axi_awready
                   : s_axi_arvalid && s_axi_arready;
            d1 = s_axi_wvalid && s_axi_wready;
            rs = w ? s_axi_bvalid : s_axi_rvalid;
            r = w ? s_axi_bresp : s_axi_rresp;
            q = s_axi_rdata;
            @(posedge clk);
            if (a1) begin
                s_axi_awvalid <= 1'b0;
                s_axi_arvalid <= 1'b0;
            end
            if (d1)
                s_axi_wvalid <= 1'b0;
            if (rs) begin
                s_axi_bready <= 1'b0;
                s_axi_rready <= 1'b0;
            end
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic [1:0] r;
        axi(1'b1, a, d, q, r);
        chk(32'(r), 32'(RESP_OKAY));
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
        logic [31:0] q;
        logic [1:0] r;
        axi(1'b0, a, 32'h0, q, r);
        chk(32'(r), 32'(RESP_OKAY));
        chk(q & m, e);
    endtask
    // fault on a random phase, the other two at half of it
    task automatic pins(input logic s, input logic c,
                        input logic [7:0] cur, input logic [7:0] res);
        int p;
        p = $unsigned($random(seed)) % 3;
        @(posedge clk);
        generalStartInput <= s;
        closeCmd <= c;
        phaseCurrentA <= (p == 0) ? cur : cur >> 1;
        phaseCurrentB <= (p == 1) ? cur : cur >> 1;
        phaseCurrentC <= (p == 2) ? cur : cur >> 1;
        residualCurrent <= res;
        repeat (12) @(posedge clk);
    endtask
    function automatic logic [31:0] cl(input logic [31:0] v, lo, hi);
        return (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction
    initial begin
        logic [31:0] q, v;
        logic [1:0] r;
        seed = 32'h4e47;
        {clk, generalStartInput, blockInput, closeCmd} = '0;
        {phaseCurrentA, phaseCurrentB, phaseCurrentC, residualCurrent} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_wstrb} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        rst = 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd(OFF_CTRL, 32'hffff, 32'(MODE_OFF));
        rd(OFF_LIMITS, 32'hffff, {16'h0, RES_DEF, PH_DEF});
        rd(OFF_DELAY, 32'hffff, 32'(DELAY_DEF));
        rd(OFF_PULSE, 32'hffff, 32'(PULSE_DEF));
        rd(OFF_STATUS, 32'h7, 32'h1);
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? 32'h0 : (i == 1) ? 32'hffff : $random(seed);
            wr(OFF_LIMITS, v);
            rd(OFF_LIMITS, 32'hffff, (cl(32'(v[15:8]), 32'(RES_MIN),
               32'(RES_MAX)) << 8) | cl(32'(v[7:0]), 32'(PH_MIN),
               32'(PH_MAX)));
            wr(OFF_DELAY, v);
            rd(OFF_DELAY, 32'hffff, cl(32'(v[15:0]), 32'(DELAY_MIN),
               32'(DELAY_MAX)));
            wr(OFF_PULSE, v);
            rd(OFF_PULSE, 32'hffff, cl(32'(v[15:0]), 32'h0,
               32'(PULSE_MAX)));
        end
        wr(OFF_LIMITS, {16'h0, RES_DEF, PH_DEF});
        axi(1'b0, 8'h1c, 32'h0, q, r);
        chk(q, 32'h0);
        chk(32'(r), 32'(RESP_SLVERR));
        axi(1'b1, 8'h40, 32'hff, q, r);
        chk(32'(r), 32'(RESP_SLVERR));
        wr(OFF_IRQMSK, 32'h7);
        pins(1'b1, 1'b1, 8'd30, 8'd0);
        rd(OFF_STATUS, 32'h7, 32'h1);
        rd(OFF_IRQST, 32'h7, 32'h0);
        wr(OFF_CTRL, 32'(MODE_CURRENT));
        rd(OFF_STATUS, 32'h7, 32'h1);
        for (int m = 1; m < 4; m++) begin
            wr(OFF_CTRL, m);
            wr(OFF_IRQMSK, (m == 1) ? 32'h6 : 32'h7);
            wr(OFF_IRQST, 32'h7);
            pins(1'b0, 1'b1, 8'd30, 8'd0);
            pins(1'b1, 1'b1, 8'd30, 8'd0);
            rd(OFF_STATUS, 32'h67, 32'h62);
            rd(OFF_IRQST, 32'h7, 32'h1);
            chk({31'h0, irq}, 32'(m != 1));
            pins(1'b1, 1'b1, 8'd29, 8'd0);
            rd(OFF_STATUS, 32'h7, (m == 1) ? 32'h1 : 32'h2);
            pins(1'b1, 1'b0, (m == 2) ? 8'd30 : 8'd29, 8'd0);
            rd(OFF_STATUS, 32'h7, 32'h1);
            rd(OFF_IRQST, 32'h6, 32'h4);
            wr(OFF_IRQST, 32'h7);
            repeat (3) @(posedge clk);
            chk({31'h0, irq}, 32'h0);
        end
        wr(OFF_CTRL, 32'(MODE_CURRENT));
        pins(1'b0, 1'b0, 8'd0, 8'd20);
        pins(1'b1, 1'b0, 8'd0, 8'd20);
        rd(OFF_STATUS, 32'h57, 32'h42);
        @(posedge clk);
        blockInput <= 1'b1;
        repeat (12) @(posedge clk);
        rd(OFF_STATUS, 32'h17, 32'h11);
        blockInput <= 1'b0;
        pins(1'b0, 1'b0, 8'd0, 8'd19);
        pins(1'b1, 1'b0, 8'd0, 8'd19);
        rd(OFF_STATUS, 32'h47, 32'h01);
        pins(1'b0, 1'b1, 8'd30, 8'd0);
        pins(1'b1, 1'b1, 8'd30, 8'd0);
        rd(OFF_STATUS, 32'h7, 32'h2);
        wr(OFF_CTRL, 32'(MODE_OFF));
        rd(OFF_STATUS, 32'h7, 32'h1);
        chk({31'h0, backupTrip}, 32'h0);
        stop_test();
    end
endmodule
